// ==== design/fra_reg_cmds.sv ====
/*
  register-access command decoder of a serial nor flash: status 2, config and
  bank reads, bank write, bank prefix, write-registers with timed completion,
  and block protection checks for memory operations.
  assumes sck, cs and si are synchronous to CLOCK and sck is far slower than it.
*/
`timescale 1ns/10ps
module fra_reg_cmds (
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  input  wire logic        CS_N,
  input  wire logic        SCK,
  input  wire logic        SI,
  input  wire logic        WP_N,
  input  wire logic [7:0]  SR2_IN,
  input  wire logic        EMBED_BUSY,
  input  wire logic        FAIL_PGM,
  input  wire logic        FAIL_ERS,
  input  wire logic        MEM_OP_VALID,
  input  wire logic        MEM_OP_BULK,
  input  wire logic [24:0] MEM_OP_ADDR,
  output logic             SO,
  output logic             SO_OE,
  output logic             WR_BUSY,
  output logic [7:0]       STATUS1,
  output logic [7:0]       CONFIG,
  output logic             EXT_ADDR_MODE,
  output logic [7:0]       BANK_HIGH_ADDR,
  output logic             MEM_OP_OK,
  output logic             MEM_OP_REFUSED
);
  import fra_pkg::*;

  fra_state_e  state_r;
  logic        sck_prev_r;
  logic        cs_prev_r;
  logic        bit_tick_r;
  logic        end_tick_r;
  logic [7:0]  opcode_r;
  logic [7:0]  data1_r;
  logic [7:0]  data2_r;
  logic [5:0]  end_cnt_r;
  logic [7:0]  sr1_r;
  logic [7:0]  cfg_r;
  logic [7:0]  bar_r;
  logic        prefix_r;
  logic        busy_r;
  logic [15:0] busy_cnt_r;
  logic [7:0]  new_sr1_r;
  logic [7:0]  new_cfg_r;
  logic        new_cfg_en_r;
  logic        fail_r;
  logic [7:0]  tx_r;
  logic [2:0]  out_cnt_r;
  logic [7:0]  rx_byte;
  logic [5:0]  rx_cnt;
  logic        sck_rise;
  logic        sck_fall;
  logic        cs_rise;
  logic        busy_now;
  logic        hw_locked;
  logic        wreg_len_ok;
  logic        is_wreg;
  logic        pfx_load;
  logic        wreg_start;
  logic        enable_done;
  logic        bank_load;
  logic [7:0]  read_val;
  logic [25:0] prot_base;
  logic        mem_prot;

  assign sck_rise = SCK && !sck_prev_r && !CS_N;
  assign sck_fall = !SCK && sck_prev_r && !CS_N;
  assign cs_rise  = CS_N && !cs_prev_r;
  assign busy_now  = busy_r || EMBED_BUSY;
  assign hw_locked   = sr1_r[SR1_LOCK_BIT] && !WP_N && !cfg_r[CFG_QUAD_BIT];
  assign wreg_len_ok = end_cnt_r == BITS_ONE || end_cnt_r == BITS_TWO;
  assign is_wreg     = end_tick_r && opcode_r == OPC_WRITE_REGS;
  assign pfx_load    = is_wreg && prefix_r && end_cnt_r >= BITS_ONE
                       && !busy_now && !sr1_r[SR1_PERR_BIT] && !sr1_r[SR1_EERR_BIT];
  assign wreg_start  = is_wreg && !prefix_r && wreg_len_ok && sr1_r[SR1_LATCH_BIT]
                       && !busy_now && !hw_locked;
  assign bank_load   = end_tick_r && opcode_r == OPC_BANK_WRITE
                       && end_cnt_r == BITS_ONE && !busy_now;
  assign enable_done = end_tick_r && opcode_r == OPC_WRITE_ENABLE
                       && end_cnt_r == BITS_OPCODE;

  fra_shift_in u_shift (
    .clk      (CLOCK),
    .rst      (SYS_RST),
    .clear    (CS_N),
    .shift_en (sck_rise),
    .bit_in   (SI),
    .byte_out (rx_byte),
    .bit_cnt  (rx_cnt)
  );

  // edge history and delayed strobes
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      sck_prev_r <= 1'b0;
      cs_prev_r  <= 1'b1;
      bit_tick_r <= 1'b0;
      end_tick_r <= 1'b0;
      end_cnt_r  <= 6'd0;
    end else begin
      sck_prev_r <= SCK;
      cs_prev_r  <= CS_N;
      bit_tick_r <= sck_rise;
      end_tick_r <= cs_rise;
      if (cs_rise) begin
        end_cnt_r <= rx_cnt;
      end
    end
  end

  // captured opcode and data bytes
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      opcode_r <= 8'h00;
      data1_r  <= 8'h00;
      data2_r  <= 8'h00;
    end else if (bit_tick_r) begin
      if (rx_cnt == BITS_OPCODE) begin
        opcode_r <= rx_byte;
      end
      if (rx_cnt == BITS_ONE) begin
        data1_r <= rx_byte;
      end
      if (rx_cnt == BITS_TWO) begin
        data2_r <= rx_byte;
      end
    end
  end

  // frame state
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      state_r <= FRA_IDLE;
    end else if (CS_N) begin
      state_r <= FRA_IDLE;
    end else begin
      unique case (state_r)
        FRA_IDLE: begin
          state_r <= FRA_OPC;
        end
        FRA_OPC: begin
          if (bit_tick_r && rx_cnt == BITS_OPCODE) begin
            if (rx_byte == OPC_STATUS_TWO_READ || rx_byte == OPC_CONFIG_READ
                || rx_byte == OPC_BANK_READ) begin
              state_r <= FRA_READ;
            end else begin
              state_r <= FRA_DATA;
            end
          end
        end
        FRA_READ: begin
          state_r <= FRA_READ;
        end
        FRA_DATA: begin
          state_r <= FRA_DATA;
        end
        default: begin
          state_r <= FRA_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    unique case (opcode_r)
      OPC_STATUS_TWO_READ: read_val = SR2_IN;
      OPC_CONFIG_READ:     read_val = cfg_r;
      default:             read_val = bar_r;
    endcase
  end

  // serial output, msb first on falling edges, refreshed each byte
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      SO        <= 1'b0;
      SO_OE     <= 1'b0;
      tx_r      <= 8'h00;
      out_cnt_r <= 3'd0;
    end else if (state_r != FRA_READ || CS_N) begin
      SO_OE     <= 1'b0;
      out_cnt_r <= 3'd0;
    end else if (sck_fall) begin
      SO_OE     <= 1'b1;
      out_cnt_r <= out_cnt_r + 3'd1;
      if (out_cnt_r == 3'd0) begin
        SO   <= read_val[7];
        tx_r <= {read_val[6:0], 1'b0};
      end else begin
        SO   <= tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // bank access prefix window
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      prefix_r <= 1'b0;
    end else if (end_tick_r) begin
      prefix_r <= opcode_r == OPC_BANK_PREFIX && end_cnt_r == BITS_OPCODE;
    end
  end

  // bank address register
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      bar_r <= BAR_RESET;
    end else if (bank_load) begin
      bar_r <= data1_r;
    end else if (pfx_load) begin
      bar_r[1:0] <= data1_r[1:0];
    end
  end

  // self-timed register write
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      busy_r       <= 1'b0;
      busy_cnt_r   <= 16'd0;
      new_sr1_r    <= SR1_RESET;
      new_cfg_r    <= CFG_RESET;
      new_cfg_en_r <= 1'b0;
    end else if (wreg_start) begin
      busy_r       <= 1'b1;
      busy_cnt_r   <= 16'(REG_WRITE_CYCLES - 1);
      new_sr1_r    <= data1_r;
      new_cfg_r    <= data2_r;
      new_cfg_en_r <= end_cnt_r == BITS_TWO;
    end else if (busy_r) begin
      if (busy_cnt_r == 16'd0) begin
        busy_r <= 1'b0;
      end else begin
        busy_cnt_r <= busy_cnt_r - 16'd1;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST || wreg_start) begin
      fail_r <= 1'b0;
    end else if (busy_r && (FAIL_PGM || FAIL_ERS)) begin
      fail_r <= 1'b1;
    end
  end

  // status register 1; a write enable landing on completion keeps the latch set
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      sr1_r <= SR1_RESET;
    end else begin
      if (busy_r && busy_cnt_r == 16'd0) begin
        if (!fail_r && !FAIL_PGM && !FAIL_ERS) begin
          sr1_r <= (sr1_r & ~SR1_WRITE_MASK) | (new_sr1_r & SR1_WRITE_MASK);
        end
        sr1_r[SR1_LATCH_BIT] <= 1'b0;
      end
      if (busy_r && FAIL_PGM) begin
        sr1_r[SR1_PERR_BIT] <= 1'b1;
      end
      if (busy_r && FAIL_ERS) begin
        sr1_r[SR1_EERR_BIT] <= 1'b1;
      end
      if (enable_done) begin
        sr1_r[SR1_LATCH_BIT] <= 1'b1;
      end
      sr1_r[SR1_BUSY_BIT] <= 1'b0;
    end
  end

  // configuration register
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      cfg_r <= CFG_RESET;
    end else if (busy_r && busy_cnt_r == 16'd0 && new_cfg_en_r && !fail_r
                 && !FAIL_PGM && !FAIL_ERS) begin
      cfg_r <= new_cfg_r;
    end
  end

  // visible status and upper address bits
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      WR_BUSY        <= 1'b0;
      STATUS1        <= SR1_RESET;
      CONFIG         <= CFG_RESET;
      EXT_ADDR_MODE  <= 1'b0;
      BANK_HIGH_ADDR <= 8'h00;
    end else begin
      WR_BUSY        <= busy_now;
      STATUS1        <= sr1_r | {7'h00, busy_now};
      CONFIG         <= cfg_r;
      EXT_ADDR_MODE  <= bar_r[BAR_EXT_BIT];
      BANK_HIGH_ADDR <= bar_r[BAR_EXT_BIT] ? 8'h00 : {1'b0, bar_r[6:0]};
    end
  end

  // block protection of program and erase requests
  assign prot_base = ARRAY_BYTES - (ARRAY_BYTES >> (3'd7 - sr1_r[SR1_BP_LSB +: 3]));
  assign mem_prot  = sr1_r[SR1_BP_LSB +: 3] != 3'd0
                     && (MEM_OP_BULK || {1'b0, MEM_OP_ADDR} >= prot_base);

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      MEM_OP_OK      <= 1'b0;
      MEM_OP_REFUSED <= 1'b0;
    end else begin
      MEM_OP_OK      <= MEM_OP_VALID && !mem_prot;
      MEM_OP_REFUSED <= MEM_OP_VALID && mem_prot;
    end
  end

  chk_enable_sets_latch: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    enable_done |=> sr1_r[SR1_LATCH_BIT])
    else $error("write enable did not set the latch");

  chk_bank_write_load: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    bank_load |=> bar_r == $past(data1_r) && sr1_r[6:5] == $past(sr1_r[6:5]))
    else $error("bank write did not load the bank register");

  chk_busy_held: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    wreg_start |=> ##1 (WR_BUSY && STATUS1[SR1_BUSY_BIT]) [*8])
    else $error("write in progress dropped early");

  chk_done_clears_latch: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    $fell(busy_r) && !$past(enable_done) |-> !sr1_r[SR1_LATCH_BIT])
    else $error("latch still set after register write");

  chk_hw_protect: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    is_wreg && !prefix_r && hw_locked && !busy_r |=> !busy_r)
    else $error("write accepted under hardware protection");

  chk_prefix_bank: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    pfx_load && !bank_load
    |=> bar_r[1:0] == $past(data1_r[1:0]) && bar_r[7:2] == $past(bar_r[7:2]))
    else $error("prefixed write loaded the bank register wrongly");

  chk_prefix_close: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    end_tick_r && opcode_r != OPC_BANK_PREFIX |=> !prefix_r)
    else $error("bank prefix stayed open");

  chk_wreg_length: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    is_wreg && !prefix_r && !wreg_len_ok && !busy_r |=> !busy_r)
    else $error("write-registers of bad length was executed");

  chk_refuse_region: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    MEM_OP_VALID && MEM_OP_BULK && sr1_r[SR1_BP_LSB +: 3] != 3'd0
    |=> MEM_OP_REFUSED && !MEM_OP_OK)
    else $error("bulk erase accepted with protection set");
endmodule

// ==== design/fra_pkg.sv ====
/*
  constants shared by the register-access command decoder of a serial nor flash.
  assumes a 20 mhz system clock; serial inputs are already synchronous to it.
*/
// Behaviour
// - opcode 07h shifts out status register 2
// - status 2 byte repeats, refreshed each byte
// - opcode 35h shifts out configuration, repeating
// - opcode 16h shifts out bank register, repeating
// - opcode 17h loads bank register, no latch
// - bank bit 7 clear gives upper address bits
// - bank write leaves fail flags, busy untouched
// - prefix then write-registers loads bank bits 1:0
// - prefixed write ignores rest, keeps bit 7, closes
// - other command or select cycle closes prefix
// - prefixed write illegal when busy or failed
// - write-registers needs write enable latch set
// - select rises at 8 or 16 data bits
// - select rise starts timed write; its end clears latch
// - failed write sets program or erase fail
// - disable bit clear lets latched writes proceed
// - disable bit set and pin low rejects writes
// - block protect bits refuse program and erase
// - quad mode disables pin write protection
// - status register resets to 00h
// - opcode 06h sets latch after eight bits
package fra_pkg;
  localparam logic [7:0] OPC_STATUS_TWO_READ = 8'h07;
  localparam logic [7:0] OPC_CONFIG_READ     = 8'h35;
  localparam logic [7:0] OPC_BANK_READ       = 8'h16;
  localparam logic [7:0] OPC_BANK_WRITE      = 8'h17;
  localparam logic [7:0] OPC_BANK_PREFIX     = 8'hB9;
  localparam logic [7:0] OPC_WRITE_REGS      = 8'h01;
  localparam logic [7:0] OPC_WRITE_ENABLE    = 8'h06;

  localparam int SR1_BUSY_BIT  = 0;
  localparam int SR1_LATCH_BIT = 1;
  localparam int SR1_BP_LSB    = 2;
  localparam int SR1_EERR_BIT  = 5;
  localparam int SR1_PERR_BIT  = 6;
  localparam int SR1_LOCK_BIT  = 7;
  localparam int CFG_QUAD_BIT  = 1;
  localparam int BAR_EXT_BIT   = 7;

  localparam logic [7:0] SR1_WRITE_MASK = 8'h9C;
  localparam logic [7:0] SR1_RESET      = 8'h00;
  localparam logic [7:0] CFG_RESET      = 8'h00;
  localparam logic [7:0] BAR_RESET      = 8'h00;

  localparam logic [5:0] BITS_OPCODE = 6'd8;
  localparam logic [5:0] BITS_ONE    = 6'd16;
  localparam logic [5:0] BITS_TWO    = 6'd24;

  localparam int CLOCK_MHZ          = 20;
  localparam int REG_WRITE_TIME_NS  = 5000;
  localparam int REG_WRITE_CYCLES   = (REG_WRITE_TIME_NS * CLOCK_MHZ + 999) / 1000;

  localparam logic [25:0] ARRAY_BYTES = 26'h2000000;

  typedef enum logic [3:0] {
    FRA_IDLE = 4'b0001,
    FRA_OPC  = 4'b0010,
    FRA_READ = 4'b0100,
    FRA_DATA = 4'b1000
  } fra_state_e;
endpackage

// ==== design/fra_shift_in.sv ====
/*
  serial input shifter: collects bits on sck rising strobes and counts them.
  assumes the caller gives one-cycle rise strobes and clears it between frames.
*/
`timescale 1ns/10ps
module fra_shift_in (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic       shift_en,
  input  wire logic       bit_in,
  output logic [7:0]      byte_out,
  output logic [5:0]      bit_cnt
);
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      byte_out <= 8'h00;
    end else if (shift_en) begin
      byte_out <= {byte_out[6:0], bit_in};
    end
  end

  always_ff @(posedge clk) begin
    if (rst || clear) begin
      bit_cnt <= 6'd0;
    end else if (shift_en && bit_cnt != 6'h3F) begin
      bit_cnt <= bit_cnt + 6'd1;
    end
  end
endmodule

// ==== verif/fra_spi_host.sv ====
/*
  spi host model: drives select, serial clock and data, captures serial out.
  assumes CLOCK is far faster than sck; sck half period is four CLOCK cycles.
*/
`timescale 1ns/10ps
module fra_spi_host (
  input  wire logic clk,
  input  wire logic so,
  output logic      cs_n,
  output logic      sck,
  output logic      si
);
  logic [15:0] rx;

  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
    rx   = 16'h0000;
  end

  // sends ntx bits msb first, then clocks nrx bits in; select rises after the last bit
  task automatic xfer(input logic [31:0] tx, input int ntx, input int nrx);
    rx = 16'h0000;
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = 0; i < ntx + nrx; i++) begin
      si = (i < ntx) ? tx[ntx-1-i] : ~si;
      repeat (4) @(negedge clk);
      sck = 1'b1;
      if (i >= ntx) rx = {rx[14:0], so};
      repeat (4) @(negedge clk);
      sck = 1'b0;
    end
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    si = ~si;
    repeat (4) @(negedge clk);
  endtask
endmodule

// ==== verif/tb_fra_reg_cmds.sv ====
/*
  testbench of the register-access command decoder: table of a bank write and reads, then writes,
  protection, bank prefix, busy and fail cases.
  assumes the spi host model and design files are compiled before it.
*/
`timescale 1ns/10ps
module tb_fra_reg_cmds;
  import fra_pkg::*;
  typedef struct {
    logic [31:0] tx;
    int          ntx;
    int          nrx;
    logic [15:0] exp;
  } fra_row_s;
  logic        clk, rst, cs_n, sck, si, wp_n, busy, f_pgm, f_ers, op_v, op_bulk;
  logic        so, so_oe, wbusy, ext_mode, op_ok, op_ref;
  logic [7:0]  sr2, st1, cfg, bank_hi;
  logic [24:0] op_addr;
  logic [1:0]  opr;
  int          errors, n_tests;
  fra_row_s    rows [4];

  fra_spi_host host_u (.clk(clk), .so(so), .cs_n(cs_n), .sck(sck), .si(si));

  fra_reg_cmds dut_u (
    .CLOCK(clk), .SYS_RST(rst), .CS_N(cs_n), .SCK(sck), .SI(si), .WP_N(wp_n),
    .SR2_IN(sr2), .EMBED_BUSY(busy), .FAIL_PGM(f_pgm), .FAIL_ERS(f_ers),
    .MEM_OP_VALID(op_v), .MEM_OP_BULK(op_bulk), .MEM_OP_ADDR(op_addr), .SO(so),
    .SO_OE(so_oe), .WR_BUSY(wbusy), .STATUS1(st1), .CONFIG(cfg), .EXT_ADDR_MODE(ext_mode),
    .BANK_HIGH_ADDR(bank_hi), .MEM_OP_OK(op_ok), .MEM_OP_REFUSED(op_ref)
  );

  always #25 clk = ~clk;

  task automatic complete_run();
    $display("errors=%0d tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  // waits for the timed write to finish, bounded
  task automatic wdone();
    int k;
    repeat (3) @(negedge clk);
    for (k = 0; k < 400 && wbusy !== 1'b0; k++) @(negedge clk);
    if (k == 400) begin
      errors++;
      $display("[ERR] %0t write never finished", $time);
      complete_run();
    end
  endtask

  task automatic wr(input logic [31:0] tx, input int ntx);
    host_u.xfer(tx, ntx, 0);
    wdone();
  endtask

  // memory operation check; result {refused, ok} over two cycles
  task automatic mop(input logic [24:0] a, input logic b);
    op_addr = a;
    op_bulk = b;
    op_v = 1'b1;
    @(negedge clk);
    op_v = 1'b0;
    opr = {op_ref, op_ok};
    @(negedge clk);
    opr = opr | {op_ref, op_ok};
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    wp_n = 1'b1;
    busy = 1'b0;
    f_pgm = 1'b0;
    f_ers = 1'b0;
    op_v = 1'b0;
    op_bulk = 1'b0;
    op_addr = 25'h0000000;
    sr2 = 8'hA5;
    errors = 0;
    n_tests = 0;
    rows[0] = '{32'h1705, 16, 0, 16'h0000};
    rows[1] = '{32'h16, 8, 16, 16'h0505};
    rows[2] = '{32'h07, 8, 16, 16'hA5A5};
    rows[3] = '{32'h35, 8, 8, 16'h0000};
    repeat (6) @(negedge clk);
    rst = 1'b0;
    chk({wbusy, st1, cfg}, 24'h0);
    for (int i = 0; i < 4; i++) begin
      host_u.xfer(rows[i].tx, rows[i].ntx, rows[i].nrx);
      chk({so_oe, host_u.rx}, {1'b0, rows[i].exp});
    end
    host_u.xfer(32'h06, 8, 0);
    chk(st1, 8'h02);
    host_u.xfer(32'h011C, 16, 0);
    repeat (4) @(negedge clk);
    chk(wbusy, 1'b1);
    wdone();
    chk(st1, 8'h1C);
    mop(25'h0000000, 1'b0);
    chk(opr, 2'b10);
    wr(32'h0100, 16);
    chk(st1, 8'h1C);
    host_u.xfer(32'h06, 8, 0);
    wr(32'h01000, 20);
    chk(st1, 8'h1E);
    wr(32'h018000, 24);
    chk({st1, cfg}, 16'h8000);
    wp_n = 1'b0;
    host_u.xfer(32'h06, 8, 0);
    wr(32'h010000, 24);
    chk(st1, 8'h82);
    wp_n = 1'b1;
    wr(32'h018002, 24);
    chk({st1, cfg}, 16'h8002);
    wp_n = 1'b0;
    host_u.xfer(32'h06, 8, 0);
    wr(32'h010002, 24);
    chk({st1, cfg}, 16'h0002);
    wp_n = 1'b1;
    mop(25'h1FFFFFF, 1'b1);
    chk(opr, 2'b01);
    host_u.xfer(32'hB9, 8, 0);
    wr(32'h01FFAA, 24);
    chk({bank_hi, st1, cfg}, 24'h070002);
    host_u.xfer(32'hB9, 8, 0);
    host_u.xfer(32'h06, 8, 0);
    wr(32'h010402, 24);
    chk({bank_hi, st1}, 16'h0704);
    mop(25'h1F80000, 1'b0);
    chk(opr, 2'b10);
    mop(25'h1F7FFFF, 1'b0);
    chk(opr, 2'b01);
    mop(25'h0000000, 1'b1);
    chk(opr, 2'b10);
    host_u.xfer(32'h1781, 16, 0);
    chk({ext_mode, bank_hi}, 9'h100);
    busy = 1'b1;
    sr2 = 8'h3C;
    host_u.xfer(32'h1700, 16, 0);
    host_u.xfer(32'h07, 8, 8);
    chk({wbusy, ext_mode, host_u.rx[7:0]}, 10'h33C);
    busy = 1'b0;
    host_u.xfer(32'h06, 8, 0);
    host_u.xfer(32'h010402, 24, 0);
    repeat (10) @(negedge clk);
    f_pgm = 1'b1;
    @(negedge clk);
    f_pgm = 1'b0;
    wdone();
    chk(st1, 8'h44);
    host_u.xfer(32'h06, 8, 0);
    host_u.xfer(32'h010402, 24, 0);
    repeat (10) @(negedge clk);
    f_ers = 1'b1;
    @(negedge clk);
    f_ers = 1'b0;
    wdone();
    chk(st1, 8'h64);
    host_u.xfer(32'hB9, 8, 0);
    wr(32'h010202, 24);
    host_u.xfer(32'h16, 8, 8);
    chk(host_u.rx, 16'h0081);
    host_u.xfer(32'h1701, 16, 0);
    chk({st1, bank_hi}, 16'h6401);
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk({st1, cfg, bank_hi}, 24'h0);
    complete_run();
  end
endmodule
